// ---- eif_regs.svh ----
// register map, field positions and timing constants of the extended interrupt block
`ifndef EIF_REGS_SVH
`define EIF_REGS_SVH

// register indices on the plain register port
`define EIF_ADDR_W 8
`define EIF_ADDR_CTRL2 8'h07
`define EIF_ADDR_FILT0 8'h08
`define EIF_ADDR_FILT1 8'h09
`define EIF_ADDR_FILT2 8'h0A
`define EIF_ADDR_FILT3 8'h0B
`define EIF_ADDR_STA0 8'h0C

// word store layout
`define EIF_WORDS 5
`define EIF_IDX_W 3
`define EIF_WORD_W 16
`define EIF_IDX_STA0 3'h4

// control word field positions
`define EIF_B_RX_DEMAND 13
`define EIF_B_CHAIN_POLL_DIS 12
`define EIF_B_ST_FLAG 11
`define EIF_B_ST_EN 10
`define EIF_B_MRE_FLAG 9
`define EIF_B_MRE_EN 8
`define EIF_B_MAP_FLAG 7
`define EIF_B_MAP_EN 6
`define EIF_B_HCD_FLAG 5
`define EIF_B_HCD_EN 4
`define EIF_B_ICD_FLAG 3
`define EIF_B_ICD_EN 2
`define EIF_B_PDT_FLAG 1
`define EIF_B_PDT_EN 0

// reset values
`define EIF_RST_WORD 16'h0000
`define EIF_RST_RDATA 32'h0000_0000

// software timer tick: period in ns and the cycle count derived from the clock rate
`define EIF_TIMER_W 6
`define EIF_CLK_MHZ 40
`define EIF_TICK_NS 1000
`define EIF_TICK_CYC ((`EIF_TICK_NS * `EIF_CLK_MHZ) / 1000)
`define EIF_DIV_W 12

`endif

// ---- eif_pkg.sv ----
// types shared by the extended interrupt register block
package eif_pkg;

	// which source drives the read data in the cycle after a read
	typedef enum logic [1:0] {
		EIF_RD_NONE = 2'b00,
		EIF_RD_CTRL = 2'b01,
		EIF_RD_MEM = 2'b10
	} eif_rd_src_t;

	// state of the word store
	typedef struct packed {
		logic [4:0][15:0] word;
		logic [15:0] q;
	} eif_mem_state_t;

	// state of the software timer
	typedef struct packed {
		logic [11:0] div;
		logic [5:0] count;
		logic expire;
	} eif_timer_state_t;

	// state of the register block
	typedef struct packed {
		logic rx_demand;
		logic chain_poll_dis;
		logic st_flag;
		logic st_en;
		logic mre_flag;
		logic mre_en;
		logic map_flag;
		logic map_en;
		logic hcd_flag;
		logic hcd_en;
		logic icd_flag;
		logic icd_en;
		logic pdt_flag;
		logic pdt_en;
		logic phy_prev;
		logic phy_seen;
		logic manual_poll;
		logic ee_req;
		logic ee_boot;
		eif_rd_src_t rd_src;
		logic [15:0] rd_ctrl;
	} eif_state_t;

endpackage

// ---- eif_word_mem.sv ----
// small word store for hash filter and station address, registered read
`timescale 1ns/1ps
`include "eif_regs.svh"

module eif_word_mem (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// write port
	input wire logic wr_en,
	input wire logic [2:0] wr_idx,
	input wire logic [15:0] wr_data,
	// read port, data one cycle after rd_en
	input wire logic rd_en,
	input wire logic [2:0] rd_idx,
	output logic [15:0] rd_data,
	// whole contents for the address filter
	output logic [79:0] all_words
);

	eif_pkg::eif_mem_state_t s;
	eif_pkg::eif_mem_state_t next_s;

	// write and read; a read of a word written in the same cycle sees the old value
	always_comb begin
		next_s = s;
		if (wr_en && (wr_idx < 3'(`EIF_WORDS))) begin
			next_s.word[wr_idx] = wr_data;
		end
		if (rd_en && (rd_idx < 3'(`EIF_WORDS))) begin
			next_s.q = s.word[rd_idx];
		end
	end

	// hardware reset clears every word
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.q;
	assign all_words = s.word;

endmodule

// ---- eif_soft_timer.sv ----
// software timer: counts down on a divided tick, reloads and flags at zero
`timescale 1ns/1ps
`include "eif_regs.svh"

module eif_soft_timer (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// reload value and expiry pulse
	input wire logic [5:0] reload,
	output logic expire
);

	eif_pkg::eif_timer_state_t s;
	eif_pkg::eif_timer_state_t next_s;

	// tick divider and down counter
	always_comb begin
		next_s = s;
		next_s.expire = 1'b0;
		if (s.div == 12'(`EIF_TICK_CYC - 1)) begin
			next_s.div = '0;
			if (s.count == '0) begin
				next_s.expire = 1'b1;
				next_s.count = reload;
			end else begin
				next_s.count = s.count - 6'h01;
			end
		end else begin
			next_s.div = s.div + 12'h001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign expire = s.expire;

endmodule

// ---- eif_ext_int_regs.sv ----
// extended control/interrupt register, hash filter and station address registers
`timescale 1ns/1ps
`include "eif_regs.svh"

module eif_ext_int_regs (
	// clock and resets
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sw_reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// descriptor manager
	input wire logic rx_desc_fetch,
	input wire logic chain_busy,
	output logic receive_demand,
	output logic chain_poll_disable,
	output logic manual_rx_poll,
	// management events
	input wire logic mgmt_read_error,
	input wire logic autopoll_change,
	input wire logic host_cmd_done,
	input wire logic internal_cmd_done,
	input wire logic phy_detected_status,
	// software timer
	input wire logic [5:0] soft_timer_reload,
	// interrupt
	input wire logic global_interrupt_enable,
	output logic interrupt_summary,
	output logic interrupt_output_pin,
	// initialization block load
	input wire logic init_wr,
	input wire logic [2:0] init_index,
	input wire logic [15:0] init_data,
	// eeprom load
	input wire logic eeprom_reload_command,
	input wire logic eeprom_valid,
	input wire logic [15:0] eeprom_data,
	output logic eeprom_read_req,
	// filter contents
	output logic [63:0] multicast_hash_filter,
	output logic [15:0] station_address
);

	eif_pkg::eif_state_t s;
	eif_pkg::eif_state_t next_s;

	// submodule wiring
	logic timer_expire;
	logic mem_wr;
	logic [2:0] mem_wr_idx;
	logic [15:0] mem_wr_data;
	logic mem_rd;
	logic [2:0] mem_rd_idx;
	logic [15:0] mem_q;
	logic [79:0] mem_words;

	// write decode and per-flag strobes; flag bits run timer, read error, autopoll,
	// host done, internal done, detect change
	logic wr_ctrl;
	logic [15:0] wd;
	logic [3:0] addr_hit;
	logic dem_set;
	logic dem_clr;
	logic poll_now;
	logic ee_start;
	logic phy_edge;
	logic [5:0] flag_set;
	logic [5:0] flag_clr;
	logic [5:0] pending;

	// maps a register index onto the word store: {hit, index}
	function automatic logic [3:0] mem_decode(input logic [7:0] a);
		logic [3:0] r;
		r = 4'h0;
		if (a == `EIF_ADDR_FILT0) begin
			r = 4'h8;
		end else if (a == `EIF_ADDR_FILT1) begin
			r = 4'h9;
		end else if (a == `EIF_ADDR_FILT2) begin
			r = 4'hA;
		end else if (a == `EIF_ADDR_FILT3) begin
			r = 4'hB;
		end else if (a == `EIF_ADDR_STA0) begin
			r = {1'b1, `EIF_IDX_STA0};
		end
		return r;
	endfunction

	// sticky flag: a hardware set in the clearing cycle wins
	function automatic logic flag_next(input logic cur, input logic set, input logic wclr);
		return set | (cur & ~wclr);
	endfunction

	// control word as software reads it
	function automatic logic [15:0] ctrl_word(input eif_pkg::eif_state_t v);
		logic [15:0] w;
		w = `EIF_RST_WORD;
		w[`EIF_B_RX_DEMAND] = v.rx_demand;
		w[`EIF_B_CHAIN_POLL_DIS] = v.chain_poll_dis;
		w[`EIF_B_ST_FLAG] = v.st_flag;
		w[`EIF_B_ST_EN] = v.st_en;
		w[`EIF_B_MRE_FLAG] = v.mre_flag;
		w[`EIF_B_MRE_EN] = v.mre_en;
		w[`EIF_B_MAP_FLAG] = v.map_flag;
		w[`EIF_B_MAP_EN] = v.map_en;
		w[`EIF_B_HCD_FLAG] = v.hcd_flag;
		w[`EIF_B_HCD_EN] = v.hcd_en;
		w[`EIF_B_ICD_FLAG] = v.icd_flag;
		w[`EIF_B_ICD_EN] = v.icd_en;
		w[`EIF_B_PDT_FLAG] = v.pdt_flag;
		w[`EIF_B_PDT_EN] = v.pdt_en;
		return w;
	endfunction

	// flags that are set and enabled, same bit order as the strobes
	function automatic logic [5:0] pending_of(input eif_pkg::eif_state_t v);
		logic [5:0] p;
		p = 6'h00;
		p[5] = v.st_flag & v.st_en;
		p[4] = v.mre_flag & v.mre_en;
		p[3] = v.map_flag & v.map_en;
		p[2] = v.hcd_flag & v.hcd_en;
		p[1] = v.icd_flag & v.icd_en;
		p[0] = v.pdt_flag & v.pdt_en;
		return p;
	endfunction

	// which source answers a read strobe at this index
	function automatic eif_pkg::eif_rd_src_t rd_source(input logic [7:0] a, input logic hit);
		eif_pkg::eif_rd_src_t r;
		r = eif_pkg::EIF_RD_NONE;
		if (a == `EIF_ADDR_CTRL2) begin
			r = eif_pkg::EIF_RD_CTRL;
		end else if (hit) begin
			r = eif_pkg::EIF_RD_MEM;
		end
		return r;
	endfunction

	// software timer keeps running from reset on
	eif_soft_timer u_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.reload(soft_timer_reload),
		.expire(timer_expire)
	);

	// write decode; bits 31..16 of write data are simply dropped
	assign wr_ctrl = reg_wr && (reg_addr == `EIF_ADDR_CTRL2);
	assign wd = reg_wdata[15:0];
	assign addr_hit = mem_decode(reg_addr);

	// control write decode and hardware events, one bit per sticky flag
	always_comb begin
		dem_set = wr_ctrl && wd[`EIF_B_RX_DEMAND];
		dem_clr = rx_desc_fetch || sw_reset;
		poll_now = dem_set && s.chain_poll_dis && chain_busy;
		ee_start = s.ee_boot || eeprom_reload_command;
		phy_edge = s.phy_seen & (phy_detected_status ^ s.phy_prev);
		flag_set = {timer_expire, mgmt_read_error, autopoll_change,
			host_cmd_done, internal_cmd_done, phy_edge};
		flag_clr = 6'h00;
		if (wr_ctrl) begin
			flag_clr = {wd[`EIF_B_ST_FLAG], wd[`EIF_B_MRE_FLAG], wd[`EIF_B_MAP_FLAG],
				wd[`EIF_B_HCD_FLAG], wd[`EIF_B_ICD_FLAG], wd[`EIF_B_PDT_FLAG]};
		end
	end

	// word store write port: software beats init block beats eeprom
	always_comb begin
		mem_wr = 1'b0;
		mem_wr_idx = '0;
		mem_wr_data = '0;
		if (reg_wr && addr_hit[3]) begin
			mem_wr = 1'b1;
			mem_wr_idx = addr_hit[2:0];
			mem_wr_data = wd;
		end else if (init_wr) begin
			mem_wr = 1'b1;
			mem_wr_idx = init_index;
			mem_wr_data = init_data;
		end else if (eeprom_valid) begin
			mem_wr = 1'b1;
			mem_wr_idx = `EIF_IDX_STA0;
			mem_wr_data = eeprom_data;
		end
	end

	// read of a stored word is started at once; data leaves the store's own register
	assign mem_rd = reg_rd && addr_hit[3];
	assign mem_rd_idx = addr_hit[2:0];

	eif_word_mem u_mem (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(mem_wr),
		.wr_idx(mem_wr_idx),
		.wr_data(mem_wr_data),
		.rd_en(mem_rd),
		.rd_idx(mem_rd_idx),
		.rd_data(mem_q),
		.all_words(mem_words)
	);

	// next state of the control word and its helpers
	always_comb begin
		next_s = s;
		next_s.manual_poll = 1'b0;
		next_s.ee_req = 1'b0;
		next_s.ee_boot = 1'b0;

		// receive demand: write 1 sets, fetch or soft reset clears, set wins
		if (dem_set) begin
			next_s.rx_demand = 1'b1;
		end else if (dem_clr) begin
			next_s.rx_demand = 1'b0;
		end

		// manual poll of the current descriptor during a chaining operation
		if (poll_now) begin
			next_s.manual_poll = 1'b1;
		end

		// plain read/write bits; soft reset does not touch them
		if (wr_ctrl) begin
			next_s.chain_poll_dis = wd[`EIF_B_CHAIN_POLL_DIS];
			next_s.st_en = wd[`EIF_B_ST_EN];
			next_s.mre_en = wd[`EIF_B_MRE_EN];
			next_s.map_en = wd[`EIF_B_MAP_EN];
			next_s.hcd_en = wd[`EIF_B_HCD_EN];
			next_s.icd_en = wd[`EIF_B_ICD_EN];
			next_s.pdt_en = wd[`EIF_B_PDT_EN];
		end

		// sticky event flags, cleared by writing 1 only
		next_s.st_flag = flag_next(s.st_flag, flag_set[5],
			flag_clr[5]);
		next_s.mre_flag = flag_next(s.mre_flag, flag_set[4],
			flag_clr[4]);
		next_s.map_flag = flag_next(s.map_flag, flag_set[3],
			flag_clr[3]);
		next_s.hcd_flag = flag_next(s.hcd_flag, flag_set[2],
			flag_clr[2]);
		next_s.icd_flag = flag_next(s.icd_flag, flag_set[1],
			flag_clr[1]);

		// detect status edge in either direction; first sample only primes the history
		next_s.phy_prev = phy_detected_status;
		next_s.phy_seen = 1'b1;
		next_s.pdt_flag = flag_next(s.pdt_flag, flag_set[0],
			flag_clr[0]);

		// eeprom fetch request once after hardware reset and on each reload command
		if (ee_start) begin
			next_s.ee_req = 1'b1;
		end

		// read source for the cycle after the strobe
		next_s.rd_src = eif_pkg::EIF_RD_NONE;
		next_s.rd_ctrl = `EIF_RST_WORD;
		if (reg_rd) begin
			next_s.rd_src = rd_source(reg_addr, addr_hit[3]);
		end
		// control word captured at the strobe, so an event after it waits for the next read
		if (reg_rd && (reg_addr == `EIF_ADDR_CTRL2)) begin
			next_s.rd_ctrl = ctrl_word(s);
		end
	end

	// hardware reset clears everything; ee_boot comes up set to fire one request
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.ee_boot <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// read data: zero for unmapped indices and for the upper half
	always_comb begin
		reg_rdata = `EIF_RST_RDATA;
		case (s.rd_src)
			eif_pkg::EIF_RD_CTRL: begin
				reg_rdata = {16'h0000, s.rd_ctrl};
			end
			eif_pkg::EIF_RD_MEM: begin
				reg_rdata = {16'h0000, mem_q};
			end
			default: begin
				reg_rdata = `EIF_RST_RDATA;
			end
		endcase
	end

	// interrupt summary: any set flag whose enable is on
	always_comb begin
		pending = pending_of(s);
		interrupt_summary = |pending;
	end

	// the pin is gated by the global enable only; a flag kept off the pin by it still shows in the summary
	assign interrupt_output_pin = interrupt_summary & global_interrupt_enable;

	// outputs toward the descriptor manager and filters
	assign receive_demand = s.rx_demand;
	assign chain_poll_disable = s.chain_poll_dis;
	assign manual_rx_poll = s.manual_poll;
	assign eeprom_read_req = s.ee_req;
	assign multicast_hash_filter = mem_words[63:0];
	assign station_address = mem_words[79:64];

endmodule

// ---- eif_asserts.sv ----
// checker of the extended interrupt register block, bound to its ports
`timescale 1ns/1ps
`include "eif_regs.svh"
module eif_asserts (
	// clock and resets
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sw_reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [31:0] reg_rdata,
	// descriptor manager
	input wire logic rx_desc_fetch,
	input wire logic chain_busy,
	input wire logic receive_demand,
	input wire logic chain_poll_disable,
	input wire logic manual_rx_poll,
	// interrupt and loads
	input wire logic global_interrupt_enable,
	input wire logic interrupt_summary,
	input wire logic interrupt_output_pin,
	input wire logic init_wr,
	input wire logic eeprom_valid,
	input wire logic eeprom_reload_command,
	input wire logic eeprom_read_req,
	input wire logic [63:0] multicast_hash_filter,
	input wire logic [15:0] station_address
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// write decodes
	wire logic ctl_wr = reg_wr && reg_addr == `EIF_ADDR_CTRL2;
	wire logic dem_wr = ctl_wr && reg_wdata[13];
	a_pin_gated: assert property (interrupt_output_pin == (interrupt_summary && global_interrupt_enable))
		else $error("interrupt pin not gated by summary and global enable");
	a_demand_set: assert property (dem_wr |=> receive_demand)
		else $error("demand not set by write");
	a_demand_fetch: assert property (receive_demand && rx_desc_fetch && !dem_wr |=> !receive_demand)
		else $error("demand not cleared by fetch");
	a_demand_hold: assert property (receive_demand && !rx_desc_fetch && !sw_reset |=> receive_demand)
		else $error("demand lost without cause");
	a_demand_cause: assert property ($rose(receive_demand) |-> $past(dem_wr))
		else $error("demand rose without write");
	a_poll_manual: assert property (dem_wr && chain_poll_disable && chain_busy |=> manual_rx_poll)
		else $error("manual poll missing");
	a_poll_cause: assert property (manual_rx_poll |-> $past(chain_busy))
		else $error("manual poll without chaining");
	a_poll_write: assert property (ctl_wr |=> chain_poll_disable == $past(reg_wdata[12]))
		else $error("poll disable not written");
	a_poll_keep: assert property (!ctl_wr |=> $stable(chain_poll_disable))
		else $error("poll disable changed without write");
	a_rsv_zero: assert property (reg_rdata[31:16] == 16'h0000)
		else $error("reserved read bits not zero");
	a_filt_write: assert property (reg_wr && reg_addr == `EIF_ADDR_FILT0
		|=> multicast_hash_filter[15:0] == $past(reg_wdata[15:0]))
		else $error("filter word not written");
	a_sta_write: assert property (reg_wr && reg_addr == `EIF_ADDR_STA0
		|=> station_address == $past(reg_wdata[15:0]))
		else $error("station word not written");
	a_sta_keep: assert property (!reg_wr && !init_wr && !eeprom_valid |=> $stable(station_address))
		else $error("station word changed without load");
	a_ee_request: assert property (eeprom_reload_command |-> ##[1:2] eeprom_read_req)
		else $error("eeprom read request missing");
	// main scenarios
	c_manual: cover property (manual_rx_poll);
	c_pin: cover property (interrupt_output_pin);
	c_eeprom: cover property (eeprom_read_req);
endmodule

bind eif_ext_int_regs eif_asserts eif_asserts_inst (.ref_clk, .rst_n, .sw_reset, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rdata, .rx_desc_fetch, .chain_busy, .receive_demand,
	.chain_poll_disable, .manual_rx_poll, .global_interrupt_enable, .interrupt_summary,
	.interrupt_output_pin, .init_wr, .eeprom_valid, .eeprom_reload_command, .eeprom_read_req,
	.multicast_hash_filter, .station_address);

// ---- test_eif_ext_int_regs.sv ----
// self-checking testbench of the extended interrupt register block
`timescale 1ns/1ps
`include "eif_regs.svh"
module test_eif_ext_int_regs;
	localparam logic [7:0] ctl = `EIF_ADDR_CTRL2;
	// stimulus and observed outputs
	logic ref_clk, rst_n, sw_reset, reg_wr, reg_rd, rx_desc_fetch, chain_busy, phy, gie;
	logic init_wr, ee_cmd, ee_valid;
	logic [3:0] ev;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, d;
	logic [2:0] init_index;
	logic [15:0] ld;
	logic [5:0] stv;
	wire logic [31:0] reg_rdata;
	wire logic receive_demand, chain_poll_disable, manual_rx_poll, interrupt_summary;
	wire logic interrupt_output_pin, eeprom_read_req;
	wire logic [63:0] multicast_hash_filter;
	wire logic [15:0] station_address;
	int n_fail, n_compared;
	time t0, t1;

	eif_ext_int_regs eif_ext_int_regs_inst (.ref_clk, .rst_n, .sw_reset, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .rx_desc_fetch, .chain_busy, .receive_demand,
		.chain_poll_disable, .manual_rx_poll, .mgmt_read_error(ev[0]), .autopoll_change(ev[1]),
		.host_cmd_done(ev[2]), .internal_cmd_done(ev[3]), .phy_detected_status(phy),
		.soft_timer_reload(stv), .global_interrupt_enable(gie), .interrupt_summary,
		.interrupt_output_pin, .init_wr, .init_index, .init_data(ld),
		.eeprom_reload_command(ee_cmd), .eeprom_valid(ee_valid), .eeprom_data(ld),
		.eeprom_read_req, .multicast_hash_filter, .station_address);

	// 40 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= {16'h0000, v};
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// one-cycle strobe: 0..3 events, 4 phy toggle, 5 sw reset, 6 fetch, 7 init, 8 eeprom data, 9 eeprom reload
	task pulse(input int k);
		@(posedge ref_clk);
		case (k)
			4: phy <= !phy;
			5: sw_reset <= 1'b1;
			6: rx_desc_fetch <= 1'b1;
			7: init_wr <= 1'b1;
			8: ee_valid <= 1'b1;
			9: ee_cmd <= 1'b1;
			default: ev[k] <= 1'b1;
		endcase
		@(posedge ref_clk);
		{ev, sw_reset, rx_desc_fetch, init_wr, ee_valid, ee_cmd} <= '0;
		#1;
	endtask

	// bounded wait on the summary, sampled at the falling edge
	task wait_sum(input logic v);
		repeat (400) begin
			@(negedge ref_clk);
			if (interrupt_summary === v)
				break;
		end
		t0 = $time;
	endtask

	// timer flag masked: it may fire before the reads end
	task t_reset();
		for (int a = 7; a <= 12; a++) begin
			rd(8'(a));
			chk(d & 32'hFFFF_F7FF, '0);
		end
		$display("test reset done");
	endtask

	task t_flags();
		logic [15:0] f;
		logic [15:0] e;
		for (int i = 0; i < 5; i++) begin
			f = 16'h0200 >> (2 * i);
			e = f >> 1;
			@(posedge ref_clk) gie <= i[0];
			wr(ctl, 16'h0000);
			pulse(i);
			rd(ctl);
			chk(d & f, f);
			wr(ctl, 16'h0155 & ~e);
			chk(interrupt_summary, 0);
			wr(ctl, e);
			chk(interrupt_summary, 1);
			chk(interrupt_output_pin, i % 2);
			pulse(5);
			rd(ctl);
			chk(d & (f | e), f | e);
			wr(ctl, f | e);
			chk(interrupt_summary, 0);
		end
		$display("test flags done");
	endtask

	// expiries reload+1 ticks of 40 cycles apart: 3 with reload 2, then 5 with reload 4
	task t_timer();
		wr(ctl, 16'h0C00);
		wait_sum(1);
		t1 = t0;
		wr(ctl, 16'h0C00);
		wait_sum(0);
		wait_sum(1);
		chk(t0 - t1, 64'h0000_0BB8);
		// new reload only takes effect at the following expiry
		@(posedge ref_clk) stv <= 6'h04;
		for (int n = 0; n < 2; n++) begin
			t1 = t0;
			wr(ctl, 16'h0C00);
			wait_sum(0);
			wait_sum(1);
		end
		chk(t0 - t1, 64'h0000_1388);
		$display("test timer done");
	endtask

	task t_demand();
		@(posedge ref_clk) chain_busy <= 1'b1;
		wr(ctl, 16'h1000);
		pulse(5);
		chk({chain_poll_disable, receive_demand}, 2'b10);
		wr(ctl, 16'h3000);
		chk({receive_demand, manual_rx_poll}, 2'b11);
		wr(ctl, 16'h1000);
		chk(receive_demand, 1);
		pulse(6);
		chk(receive_demand, 0);
		wr(ctl, 16'h2000);
		pulse(5);
		chk({receive_demand, chain_poll_disable}, 2'b00);
		@(posedge ref_clk) chain_busy <= 1'b0;
		$display("test demand done");
	endtask

	task t_words();
		for (int a = 8; a <= 12; a++)
			wr(8'(a), 16'((a - 7) * 16'h1111));
		pulse(5);
		for (int a = 8; a <= 12; a++) begin
			rd(8'(a));
			chk(d, (a - 7) * 32'h0000_1111);
		end
		rd(8'h0D);
		chk(d, '0);
		chk(multicast_hash_filter, 64'h4444_3333_2222_1111);
		@(posedge ref_clk);
		init_index <= 3'h4;
		ld <= 16'hA5C3;
		pulse(7);
		chk(station_address, 16'hA5C3);
		@(posedge ref_clk);
		ld <= 16'h5A3C;
		pulse(9);
		chk(eeprom_read_req, 1);
		pulse(8);
		chk(station_address, 16'h5A3C);
		@(posedge ref_clk);
		init_index <= 3'h0;
		ld <= 16'h0F0F;
		pulse(7);
		chk(multicast_hash_filter[15:0], 16'h0F0F);
		$display("test words done");
	endtask

	task summarize();
		$display("compared %0d, wrong %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// main sequence
	initial begin
		{sw_reset, reg_wr, reg_rd, rx_desc_fetch, chain_busy, phy, gie} = '0;
		{init_wr, ee_cmd, ee_valid, ev, reg_addr, reg_wdata, init_index, ld} = '0;
		stv = 6'h02;
		n_fail = 0;
		n_compared = 0;
		rst_n = 1'b0;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		// one eeprom fetch request right after hardware reset
		@(posedge ref_clk);
		#1 chk(eeprom_read_req, 1);
		t_reset();
		t_flags();
		t_timer();
		t_demand();
		t_words();
		summarize();
	end

	// watchdog, well beyond the fewer than one thousand cycles the tests need
	initial begin
		#500_000;
		n_fail++;
		summarize();
	end
endmodule
